// ---- txr_regs.sv ----
// Purpose: Transmitter checksum, status and configuration registers on APB
// Assumes: Detector pins asynchronous; APB master on clock
// Notes:   Zero-wait APB slave, read data registered in setup
//
// Functional notes
// - Status bit 7 always reads one
// - Low-battery flags read live, invalid in standby
// - Brownout flag sets on event, default one
// - Lock loss sets bit 0
// - Standby command bit self-clears after taking
// - Config bits 3:2 select the RF band
// - Clear-after-write bits return to their default
`timescale 1ns/1ps
`default_nettype none
`include "txr_defines.svh"

module txr_regs
	import txr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        low_battery_lower_pin,
	input  wire logic        low_battery_upper_pin,
	input  wire logic        calibration_fail_pin,
	input  wire logic        brownout_pin,
	input  wire logic        lock_loss_pin,
	input  wire logic        wake_pin,
	output logic             enter_standby_cmd,
	output logic             standby_state,
	output logic             failsafe_disable,
	output txr_band_t        radio_band_select,
	output logic             irq
);

	txr_state_t  state_reg;
	txr_state_t  state_next;
	txr_detect_t pins;
	txr_detect_t det;
	logic [7:0]  checksum;
	logic [5:0]  index;
	logic        mapped;
	logic        setup;
	logic        access;
	logic        wr_take;
	logic        wr_byte;
	logic        parity_bad;
	logic        wr_chksum;
	logic        wr_status;
	logic        wr_cfg;
	logic        wr_istat;
	logic        wr_imask;
	logic [3:0]  flag_set;
	logic [4:0]  irq_event;
	logic [7:0]  status_view;

	function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
		hit = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
	endfunction : hit

	assign pins = '{wake:              wake_pin,
	                low_battery_lower: low_battery_lower_pin,
	                low_battery_upper: low_battery_upper_pin,
	                calibration_fail:  calibration_fail_pin,
	                brownout:          brownout_pin,
	                lock_loss:         lock_loss_pin};

	txr_sync u_sync
	(
		.clock    (clock),
		.reset    (reset),
		.async_in (pins),
		.sync_out (det)
	);

	// Bus decode
	assign index   = paddr[7:2];
	assign mapped  = hit(paddr, `TXR_IDX_CHKSUM) || hit(paddr, `TXR_IDX_STATUS)
	              || hit(paddr, `TXR_IDX_CFG0) || hit(paddr, `TXR_IDX_IRQ_STAT)
	              || hit(paddr, `TXR_IDX_IRQ_MASK);
	assign setup   = psel && !penable;
	assign access  = psel && penable;
	assign pready  = access;
	assign pslverr = access && !mapped;
	assign wr_take = access && pwrite && mapped;
	assign wr_byte = wr_take && pstrb[0];

	// Even parity over data byte and parity bit
	assign parity_bad = wr_take && (^pwdata[`TXR_PARITY_BIT:0]);

	assign wr_chksum = wr_byte && hit(paddr, `TXR_IDX_CHKSUM);
	assign wr_status = wr_byte && hit(paddr, `TXR_IDX_STATUS);
	assign wr_cfg    = wr_byte && hit(paddr, `TXR_IDX_CFG0);
	assign wr_istat  = wr_byte && hit(paddr, `TXR_IDX_IRQ_STAT);
	assign wr_imask  = wr_byte && hit(paddr, `TXR_IDX_IRQ_MASK);

	txr_checksum u_checksum
	(
		.clock (clock),
		.reset (reset),
		.take  (wr_byte && !wr_chksum),
		.clear (wr_chksum),
		.index (index),
		.data  (pwdata[7:0]),
		.value (checksum)
	);

	assign flag_set[`TXR_STAT_CAL] = det.calibration_fail;
	assign flag_set[`TXR_STAT_BRN] = det.brownout;
	assign flag_set[`TXR_STAT_PAR] = parity_bad;
	assign flag_set[`TXR_STAT_LCK] = det.lock_loss;

	assign irq_event[3:0]          = flag_set & ~state_reg.flags;
	assign irq_event[`TXR_IRQ_STANDBY_STATE] = wr_cfg && pwdata[`TXR_CFG_STANDBY_STATE];

	always_comb
	begin
		status_view = {4'h0, state_reg.flags};
		status_view[`TXR_STAT_ONE] = 1'b1;
		status_view[`TXR_STAT_LBL] = det.low_battery_lower && (state_reg.mode == TXR_ACTIVE);
		status_view[`TXR_STAT_LBU] = det.low_battery_upper && (state_reg.mode == TXR_ACTIVE);
	end

	always_comb
	begin
		state_next = state_reg;
		state_next.standby_state_pulse = 1'b0;

		// Clear-after-write returns to default; a same-cycle event wins
		if (wr_status)
			state_next.flags = `TXR_FLAGS_RESET;
		state_next.flags = state_next.flags | flag_set;

		if (wr_cfg)
			state_next.cfg = pwdata[6:0];

		unique case (state_reg.mode)
			TXR_ACTIVE:
			begin
				if (wr_cfg && pwdata[`TXR_CFG_STANDBY_STATE])
				begin
					state_next.mode        = TXR_STANDBY;
					state_next.standby_state_pulse = 1'b1;
				end
			end
			TXR_STANDBY:
			begin
				if (wr_cfg && pwdata[`TXR_CFG_STANDBY_STATE])
					state_next.standby_state_pulse = 1'b1;
				else if (det.wake)
					state_next.mode = TXR_ACTIVE;
			end
		endcase

		if (wr_istat)
			state_next.istat = state_reg.istat & ~pwdata[4:0];
		state_next.istat = state_next.istat | irq_event;
		if (wr_imask)
			state_next.imask = pwdata[4:0];

		if (setup)
		begin
			state_next.rdata = 8'h00;
			if (hit(paddr, `TXR_IDX_CHKSUM))
				state_next.rdata = checksum;
			else if (hit(paddr, `TXR_IDX_STATUS))
				state_next.rdata = status_view;
			else if (hit(paddr, `TXR_IDX_CFG0))
				state_next.rdata = {1'b0, state_reg.cfg};
			else if (hit(paddr, `TXR_IDX_IRQ_STAT))
				state_next.rdata = {3'h0, state_reg.istat};
			else if (hit(paddr, `TXR_IDX_IRQ_MASK))
				state_next.rdata = {3'h0, state_reg.imask};
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			state_reg.cfg         <= `TXR_CFG0_RESET;
			state_reg.flags       <= `TXR_FLAGS_RESET;
			state_reg.mode        <= TXR_ACTIVE;
			state_reg.istat       <= `TXR_IRQ_RESET;
			state_reg.imask       <= `TXR_IRQ_RESET;
			state_reg.rdata       <= 8'h00;
			state_reg.standby_state_pulse <= 1'b0;
		end
		else
			state_reg <= state_next;
	end

	assign prdata            = {24'h000000, state_reg.rdata};
	assign enter_standby_cmd = state_reg.standby_state_pulse;
	assign standby_state     = (state_reg.mode == TXR_STANDBY);
	assign failsafe_disable  = state_reg.cfg[`TXR_CFG_FAILSAFE_DISABLE];
	assign radio_band_select = txr_band_t'(state_reg.cfg[`TXR_CFG_BAND_HI:`TXR_CFG_BAND_LO]);
	assign irq               = |(state_reg.istat & state_reg.imask);

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	logic       reading_status;
	logic [1:0] lowbatt_now;
	assign reading_status = setup && hit(paddr, `TXR_IDX_STATUS);
	assign lowbatt_now    = {det.low_battery_lower, det.low_battery_upper};

	chk_status_msb_one: assert property (
		reading_status |=> prdata[7] && !prdata[6])
		else $error("status bit 7 not one");

	chk_lowbatt_standby: assert property (
		(reading_status && standby_state) |=> (prdata[5:4] == 2'h0))
		else $error("low battery flags visible in standby");

	chk_brownout_set: assert property (
		det.brownout |=> state_reg.flags[`TXR_STAT_BRN] ##1 state_reg.flags[`TXR_STAT_BRN])
		else $error("brownout flag not set");

	chk_parity_flag: assert property (
		(wr_take && ^pwdata[8:0]) |=> state_reg.flags[`TXR_STAT_PAR])
		else $error("parity flag not set");

	chk_lock_loss: assert property (
		(det.lock_loss && !state_reg.flags[`TXR_STAT_LCK]) |=> state_reg.flags[`TXR_STAT_LCK]
		&& irq_event[`TXR_STAT_LCK] == 1'b0)
		else $error("lock loss flag not set");

	chk_standby_cmd: assert property (
		(wr_cfg && pwdata[7]) |=> enter_standby_cmd && standby_state ##1 !enter_standby_cmd)
		else $error("standby command not taken");

	chk_failsafe_out: assert property (
		wr_cfg |=> (failsafe_disable == $past(pwdata[4])))
		else $error("fail-safe disable mismatch");

	chk_band_select: assert property (
		wr_cfg |=> (radio_band_select == txr_band_t'($past(pwdata[3:2]))) ##1 $stable(radio_band_select)
		|| $past(wr_cfg))
		else $error("band select mismatch");

	chk_clear_default: assert property (
		(wr_status && flag_set == 4'h0) |=> (state_reg.flags == `TXR_FLAGS_RESET))
		else $error("status clear not to default");

	chk_checksum_clear: assert property (
		wr_chksum |=> (checksum == 8'h00))
		else $error("checksum not cleared");

	chk_cfg_msb_zero: assert property (
		(setup && hit(paddr, `TXR_IDX_CFG0)) |=> !prdata[`TXR_CFG_STANDBY_STATE])
		else $error("standby command bit reads one");

	chk_standby_one_pulse: assert property (
		enter_standby_cmd |=> !enter_standby_cmd)
		else $error("standby command longer than one cycle");

	chk_standby_holds: assert property (
		(standby_state && !det.wake) |=> standby_state)
		else $error("standby left without wake");

	chk_wake_exit: assert property (
		(standby_state && det.wake && !(wr_cfg && pwdata[`TXR_CFG_STANDBY_STATE]))
		|=> !standby_state)
		else $error("wake did not leave standby");

	chk_lowbatt_live: assert property (
		(reading_status && !standby_state)
		|=> (prdata[`TXR_STAT_LBL:`TXR_STAT_LBU] == $past(lowbatt_now)))
		else $error("low battery flags not live");

	chk_lock_sticky: assert property (
		(state_reg.flags[`TXR_STAT_LCK] && !wr_status)
		|=> state_reg.flags[`TXR_STAT_LCK])
		else $error("lock loss flag dropped");

	chk_lock_irq: assert property (
		(det.lock_loss && !state_reg.flags[`TXR_STAT_LCK])
		|=> state_reg.istat[`TXR_STAT_LCK])
		else $error("lock loss event not latched");

	chk_parity_sticky: assert property (
		(state_reg.flags[`TXR_STAT_PAR] && !wr_status)
		|=> state_reg.flags[`TXR_STAT_PAR])
		else $error("parity flag dropped");

	chk_parity_quiet: assert property (
		(wr_take && !(^pwdata[`TXR_PARITY_BIT:0]) && !state_reg.flags[`TXR_STAT_PAR])
		|=> !state_reg.flags[`TXR_STAT_PAR])
		else $error("parity flag set on good parity");

	chk_lock_clear: assert property (
		(wr_status && !det.lock_loss)
		|=> !state_reg.flags[`TXR_STAT_LCK])
		else $error("lock loss flag not cleared");

	chk_parity_clear: assert property (
		(wr_status && !parity_bad)
		|=> !state_reg.flags[`TXR_STAT_PAR])
		else $error("parity flag not cleared");

	chk_calfail_clear: assert property (
		(wr_status && !det.calibration_fail)
		|=> !state_reg.flags[`TXR_STAT_CAL])
		else $error("calibration flag not cleared");

	chk_checksum_hold: assert property (
		!wr_byte |=> (checksum == $past(checksum)))
		else $error("checksum moved without a write");

	chk_checksum_read: assert property (
		(setup && hit(paddr, `TXR_IDX_CHKSUM))
		|=> (prdata[7:0] == $past(checksum)))
		else $error("checksum read-back mismatch");

	chk_band_hold: assert property (
		!wr_cfg |=> $stable(radio_band_select))
		else $error("band select moved without a write");

	chk_failsafe_hold: assert property (
		!wr_cfg |=> $stable(failsafe_disable))
		else $error("fail-safe disable moved without a write");

	chk_cfg_readback: assert property (
		(setup && hit(paddr, `TXR_IDX_CFG0)) |=> (prdata[`TXR_CFG_FAILSAFE_DISABLE] == failsafe_disable)
		&& (prdata[`TXR_CFG_BAND_HI:`TXR_CFG_BAND_LO] == radio_band_select))
		else $error("config read-back differs from outputs");

	cov_standby_entry: cover property (wr_cfg && pwdata[7] ##1 standby_state ##[1:20] !standby_state);
	cov_irq_raised:    cover property (!irq ##1 irq);
	cov_parity_error:  cover property (parity_bad);
	cov_status_clear:  cover property (wr_status ##[1:10] reading_status);
	cov_band_change:   cover property (wr_cfg ##1 $changed(radio_band_select));

endmodule : txr_regs

`default_nettype wire

// ---- txr_defines.svh ----
// Purpose: Register indices, field positions and reset values
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef TXR_DEFINES_SVH
`define TXR_DEFINES_SVH

`define TXR_IDX_CHKSUM    6'h00
`define TXR_IDX_STATUS    6'h01
`define TXR_IDX_CFG0      6'h04
`define TXR_IDX_IRQ_STAT  6'h08
`define TXR_IDX_IRQ_MASK  6'h09

`define TXR_STAT_ONE      7
`define TXR_STAT_LBL      5
`define TXR_STAT_LBU      4
`define TXR_STAT_CAL      3
`define TXR_STAT_BRN      2
`define TXR_STAT_PAR      1
`define TXR_STAT_LCK      0
`define TXR_FLAGS_RESET   4'h4

`define TXR_CFG_STANDBY_STATE     7
`define TXR_CFG_FAILSAFE_DISABLE     4
`define TXR_CFG_BAND_HI   3
`define TXR_CFG_BAND_LO   2
`define TXR_CFG0_RESET    7'h06

`define TXR_IRQ_STANDBY_STATE     4
`define TXR_IRQ_RESET     5'h00
`define TXR_PARITY_BIT    8
`define TXR_CHKSUM_RESET  8'h00

`endif

// ---- txr_pkg.sv ----
// Purpose: Shared types of the transmitter register bank
// Assumes: Constants come from txr_defines.svh
// Notes:   Types only
package txr_pkg;

	typedef enum logic
	{
		TXR_ACTIVE,
		TXR_STANDBY
	} txr_mode_t;

	typedef enum logic [1:0]
	{
		TXR_BAND_300,
		TXR_BAND_433,
		TXR_BAND_863,
		TXR_BAND_902
	} txr_band_t;

	// Detector levels from the analog side
	typedef struct packed
	{
		logic wake;
		logic low_battery_lower;
		logic low_battery_upper;
		logic calibration_fail;
		logic brownout;
		logic lock_loss;
	} txr_detect_t;

	typedef struct packed
	{
		txr_detect_t first;
		txr_detect_t second;
	} txr_sync_state_t;

	typedef struct packed
	{
		logic [7:0] sum;
	} txr_cks_state_t;

	typedef struct packed
	{
		logic [6:0] cfg;
		logic [3:0] flags;
		txr_mode_t  mode;
		logic [4:0] istat;
		logic [4:0] imask;
		logic [7:0] rdata;
		logic       standby_state_pulse;
	} txr_state_t;

endpackage : txr_pkg

// ---- txr_sync.sv ----
// Purpose: Two-stage synchroniser for detector pins
// Assumes: Pins are asynchronous to clock
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none

module txr_sync
	import txr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire txr_detect_t async_in,
	output var  txr_detect_t sync_out
);

	txr_sync_state_t state_reg;
	txr_sync_state_t state_next;

	always_comb
	begin
		state_next.first  = async_in;
		state_next.second = state_reg.first;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign sync_out = state_reg.second;

endmodule : txr_sync

`default_nettype wire

// ---- txr_checksum.sv ----
// Purpose: Running checksum of register write traffic
// Assumes: take and clear are one-cycle pulses on clock
// Notes:   Rotate-left then xor of index and data
`timescale 1ns/1ps
`default_nettype none
`include "txr_defines.svh"

module txr_checksum
	import txr_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       take,
	input  wire logic       clear,
	input  wire logic [5:0] index,
	input  wire logic [7:0] data,
	output logic      [7:0] value
);

	txr_cks_state_t state_reg;
	txr_cks_state_t state_next;

	always_comb
	begin
		state_next = state_reg;
		if (clear)
			state_next.sum = `TXR_CHKSUM_RESET;
		// A same-cycle take accumulates onto the cleared sum
		if (take)
			state_next.sum = {state_next.sum[6:0], state_next.sum[7]} ^ data ^ {2'h0, index};
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			state_reg.sum <= `TXR_CHKSUM_RESET;
		else
			state_reg <= state_next;
	end

	assign value = state_reg.sum;

endmodule : txr_checksum

`default_nettype wire

// ---- txr_host_model.sv ----
// Purpose: Host model that drives the register port
// Assumes: Slave may add wait states; pready ends the access
// Notes:   Tasks are called from tb_top; released write data is inverted
`timescale 1ns/1ps
`default_nettype none

module txr_host_model
(
	input  wire logic        clock,
	output logic      [7:0]  paddr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [31:0] pwdata,
	output logic      [3:0]  pstrb,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	logic [31:0] rd_data;
	logic        rd_err;

	initial
	begin
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
	end

	// Bad flips the even parity bit
	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d, input logic bad);
		@(posedge clock);
		paddr <= a;
		pwrite <= w;
		pwdata <= {23'h00_0000, (^d) ^ bad, d};
		pstrb <= 4'hF;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge clock);
		penable <= 1'b1;
		do
		begin
			@(posedge clock);
		end
		while (pready !== 1'b1);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~pwdata;
	endtask : xfer

	// Reserved bits written with defaults: 6,5,0 low, 1 high
	task automatic wr_cfg(input logic [1:0] band, input logic fs, input logic go);
		xfer(8'h10, 1'b1, {go, 2'b00, fs, band, 2'b10}, 1'b0);
	endtask : wr_cfg
endmodule : txr_host_model

`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench of the transmitter register bank
// Assumes: Zero-wait slave; pin to flag takes three cycles
// Notes:   Reset-value reads first, then table loop, then hand-written cases
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb_top;
	import txr_pkg::*;
	localparam logic [7:0] A_CKS = 8'h00, A_STA = 8'h04, A_CFG = 8'h10;
	localparam logic [7:0] A_IST = 8'h20, A_IMK = 8'h24;
	typedef struct packed { logic [7:0] a; logic [7:0] wd; logic [7:0] ex; } tb_row_t;
	localparam tb_row_t ROWS [6] = '{'{A_CFG, 8'h02, 8'h02}, '{A_CFG, 8'h16, 8'h16},
		'{A_CFG, 8'h0A, 8'h0A}, '{A_CFG, 8'h1E, 8'h1E}, '{A_IMK, 8'h1F, 8'h1F},
		'{A_IMK, 8'h00, 8'h00}};
	logic        clock, reset, lbl, lbu, cal, brn, lck, wake;
	logic [7:0]  paddr;
	logic        psel, penable, pwrite, pready, pslverr, cmd, stby, fsd, irq;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	txr_band_t   band;
	int          error_cnt = 0, cmp_count = 0, pulses = 0;

	txr_host_model host_i (.clock(clock), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	txr_regs txr_regs_i (.clock(clock), .reset(reset), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.low_battery_lower_pin(lbl), .low_battery_upper_pin(lbu),
		.calibration_fail_pin(cal), .brownout_pin(brn), .lock_loss_pin(lck),
		.wake_pin(wake), .enter_standby_cmd(cmd), .standby_state(stby),
		.failsafe_disable(fsd), .radio_band_select(band), .irq(irq));

	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	always @(posedge clock)
		if (cmd === 1'b1)
			pulses++;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_i.xfer(a, 1'b1, d, 1'b0);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		host_i.xfer(a, 1'b0, 8'h00, 1'b0);
	endtask : rd

	task automatic final_report;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	initial
	begin
		repeat (5000) @(posedge clock);
		error_cnt++;
		final_report();
	end

	initial
	begin
		{lbl, lbu, cal, brn, lck, wake} = 6'h00;
		reset = 1'b1;
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		rd(A_STA);
		`CHK("status", 32'h84, host_i.rd_data)
		rd(A_CFG);
		`CHK("cfg0", 32'h06, host_i.rd_data)
		`CHK("band", 2'b01, band)
		rd(8'h08);
		`CHK("unmapped", 33'h1_0000_0000, {host_i.rd_err, host_i.rd_data})
		foreach (ROWS[i])
		begin
			wr(ROWS[i].a, ROWS[i].wd);
			rd(ROWS[i].a);
			`CHK("row", {24'h0, ROWS[i].ex}, host_i.rd_data)
			if (ROWS[i].a == A_CFG)
				`CHK("outs", ROWS[i].ex[4:2], {fsd, band})
		end
		wr(A_CKS, 8'h00);
		host_i.wr_cfg(2'b01, 1'b0, 1'b0);
		rd(A_CKS);
		`CHK("checksum", 32'h02, host_i.rd_data)
		wr(A_CKS, 8'h55);
		rd(A_CKS);
		`CHK("cks clear", 32'h00, host_i.rd_data)
		{lck, cal} <= 2'b11;
		repeat (6) @(posedge clock);
		{lck, cal} <= 2'b00;
		rd(A_STA);
		`CHK("lock", 32'h8D, host_i.rd_data)
		`CHK("irq masked", 1'b0, irq)
		wr(A_IMK, 8'h01);
		@(posedge clock);
		`CHK("irq on", 1'b1, irq)
		wr(A_IST, 8'h01);
		@(posedge clock);
		`CHK("irq off", 1'b0, irq)
		wr(A_STA, 8'h80);
		rd(A_STA);
		`CHK("stat clr", 32'h84, host_i.rd_data)
		host_i.xfer(A_CFG, 1'b1, 8'h06, 1'b1);
		rd(A_STA);
		`CHK("parity", 32'h86, host_i.rd_data)
		wr(A_STA, 8'h80);
		{lbl, lbu} <= 2'b11;
		repeat (6) @(posedge clock);
		rd(A_STA);
		`CHK("lowbat", 32'hB4, host_i.rd_data)
		host_i.wr_cfg(2'b01, 1'b0, 1'b1);
		rd(A_CFG);
		`CHK("go", 34'h3_0000_0006, {stby, pulses[0], host_i.rd_data})
		rd(A_STA);
		`CHK("lb standby_state", 32'h84, host_i.rd_data)
		rd(A_IST);
		`CHK("irq stat", 32'h1A, host_i.rd_data)
		{lbl, lbu, wake} <= 3'b001;
		repeat (6) @(posedge clock);
		wake <= 1'b0;
		`CHK("wake", 2'b01, {stby, pulses[0]})
		final_report();
	end
endmodule : tb_top

`default_nettype wire
